// File: rtl/lpp_defines.vh
// What this block does
// - Test mode holds until both lines idle high 500 ms, or power cycle.
// - Test mode may also be left through the configuration port command.
// - Every lane gets its own complete copy of the protocol port.
// - Send and receive widths are each chosen by a two-bit select.
// - A width change takes effect only between bursts, never mid burst.
// - Any whole number of words above zero passes at any width.
// - Each word group carries per-word valid flags on send and receive.
// - Send data is ignored while the send request is low.
// - First byte is taken on the first word clock edge with accept high.
// - Request low after last byte makes the lane stop and idle.
// - A burst of a single byte is supported.
// - Receive-active is high in reception; start pulse precedes valid data.
// - With internal end handling, active and valid fall right after last byte.
// - Without it, a filler byte of all zeros follows, then both fall.
// - After falling, active and valid stay low until the next reception.
// - Slave-side send accept is high only one cycle in four.
// - Master-side receive valid is high one cycle in four.
// - Master-side receiver may give extra valid pulses after last byte.
`ifndef LPP_DEFINES_VH
`define LPP_DEFINES_VH
`define LPP_LANES        2
`define LPP_MAX_WORDS    4
`define LPP_WIDTH_W      2
`define LPP_WIDTH_RST    2'h0
`define LPP_RATE_DIV     4
`define LPP_EXIT_MS      500
`define LPP_CLK_KHZ      40000
`define LPP_EXIT_CYCLES  (`LPP_EXIT_MS * `LPP_CLK_KHZ)
`define LPP_FILL_ONES    8'hFF
`define LPP_FILL_ZEROS   8'h00
`endif

// File: rtl/lpp_lane.v
`timescale 1ns/100ps
`include "lpp_defines.vh"
module lpp_lane (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Lane role and options
  input  wire        slave_side,
  input  wire        eob_internal,
  // Send side
  input  wire        hs_send_request,
  input  wire [31:0] hs_send_byte,
  input  wire [3:0]  hs_send_valid,
  input  wire [1:0]  send_path_width_sel,
  output wire        hs_send_accept,
  // Line serial data
  output reg  [7:0]  line_tx_byte,
  output reg         line_tx_strobe,
  output reg         line_tx_burst,
  input  wire        line_rx_burst,
  input  wire        line_rx_strobe,
  input  wire [7:0]  line_rx_byte,
  // Receive side
  input  wire [1:0]  recv_path_width_sel,
  output reg         hs_recv_active,
  output reg         hs_recv_start_pulse,
  output reg         hs_recv_valid,
  output reg  [31:0] hs_recv_byte,
  output reg  [3:0]  hs_recv_word_valid
);
  localparam ST_IDLE = 3'h1;
  localparam ST_SEND = 3'h2;
  localparam ST_STOP = 3'h4;
  reg  [2:0]  state;
  reg  [1:0]  phase;
  reg  [1:0]  tx_width;
  reg  [1:0]  rx_width;
  reg  [31:0] tx_hold;
  reg  [3:0]  tx_vld;
  reg  [1:0]  tx_idx;
  reg         tx_busy;
  reg  [1:0]  rx_idx;
  reg  [31:0] rx_acc;
  reg  [3:0]  rx_vacc;
  reg         rx_inb;
  reg         rx_sync_sent;
  reg         rx_fill_due;
  wire        rate_slot;
  wire [2:0]  tx_n;
  wire [2:0]  rx_n;
  // Slave lane sends at a quarter rate, so only one slot in four moves a sent byte; receive is not paced
  assign rate_slot = !slave_side || (phase == 2'h0);
  assign tx_n = {1'b0, tx_width} + 3'h1;
  assign rx_n = {1'b0, rx_width} + 3'h1;
  // Accept a new word group only in a burst and once the previous one is fully serialised;
  // idle only opens the burst, so an accept there would drop the first group
  assign hs_send_accept = hs_send_request && (state == ST_SEND) && !tx_busy && rate_slot;
  // Quarter-rate phase counter
  always @(posedge ref_clk) begin
    if (rst)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  // Send path: word group load, per-byte serialising, stop on request drop
  always @(posedge ref_clk) begin
    if (rst) begin
      state          <= ST_IDLE;
      tx_width       <= `LPP_WIDTH_RST;
      tx_hold        <= 32'h0;
      tx_vld         <= 4'h0;
      tx_idx         <= 2'h0;
      tx_busy        <= 1'b0;
      line_tx_byte   <= 8'h00;
      line_tx_strobe <= 1'b0;
      line_tx_burst  <= 1'b0;
    end else begin
      line_tx_strobe <= 1'b0;
      case (state)
        ST_IDLE: begin
          tx_width <= send_path_width_sel;
          if (hs_send_request) begin
            state         <= ST_SEND;
            line_tx_burst <= 1'b1;
          end
        end
        ST_SEND: begin
          if (hs_send_accept) begin
            tx_hold <= hs_send_byte;
            tx_vld  <= hs_send_valid;
            tx_idx  <= 2'h0;
            tx_busy <= 1'b1;
          end else if (tx_busy && rate_slot) begin
            // Bytes whose valid flag is low are skipped, so any count passes
            if (tx_vld[tx_idx]) begin
              line_tx_byte   <= tx_hold[tx_idx*8 +: 8];
              line_tx_strobe <= 1'b1;
            end
            tx_idx <= tx_idx + 2'h1;
            if ({1'b0, tx_idx} == tx_n - 3'h1)
              tx_busy <= 1'b0;
          end else if (!tx_busy && !hs_send_request) begin
            state         <= ST_STOP;
            line_tx_burst <= 1'b0;
          end
        end
        ST_STOP: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Receive path: start pulse, packing bytes into groups, end of burst
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_width            <= `LPP_WIDTH_RST;
      rx_idx              <= 2'h0;
      rx_acc              <= 32'h0;
      rx_vacc             <= 4'h0;
      rx_inb              <= 1'b0;
      rx_sync_sent        <= 1'b0;
      rx_fill_due         <= 1'b0;
      hs_recv_active      <= 1'b0;
      hs_recv_start_pulse <= 1'b0;
      hs_recv_valid       <= 1'b0;
      hs_recv_byte        <= 32'h0;
      hs_recv_word_valid  <= 4'h0;
    end else begin
      hs_recv_start_pulse <= 1'b0;
      hs_recv_valid       <= 1'b0;
      if (!rx_inb) begin
        rx_width <= recv_path_width_sel;
        if (line_rx_burst) begin
          rx_inb              <= 1'b1;
          hs_recv_active      <= 1'b1;
          hs_recv_start_pulse <= 1'b1;
          rx_sync_sent        <= 1'b1;
          rx_idx              <= 2'h0;
          rx_vacc             <= 4'h0;
        end
      end else if (line_rx_burst) begin
        // No back-pressure exists, every byte is taken in as it arrives and packed into its group
        if (line_rx_strobe) begin
          rx_acc[rx_idx*8 +: 8] <= line_rx_byte;
          rx_vacc[rx_idx]       <= 1'b1;
          rx_idx                <= rx_idx + 2'h1;
          if ({1'b0, rx_idx} == rx_n - 3'h1) begin
            hs_recv_byte       <= rx_acc;
            hs_recv_byte[rx_idx*8 +: 8] <= line_rx_byte;
            hs_recv_word_valid <= rx_vacc | (4'h1 << rx_idx);
            hs_recv_valid      <= 1'b1;
            rx_idx             <= 2'h0;
            rx_vacc            <= 4'h0;
          end
        end
        rx_sync_sent <= 1'b0;
      end else if (rx_vacc != 4'h0) begin
        // Partial last group goes out with only its real words flagged
        hs_recv_byte       <= rx_acc;
        hs_recv_word_valid <= rx_vacc;
        hs_recv_valid      <= 1'b1;
        rx_vacc            <= 4'h0;
        rx_fill_due        <= !eob_internal;
        rx_sync_sent       <= 1'b1; // One filler only, so valid and active fall together
      end else if (!eob_internal && !rx_fill_due && hs_recv_active && !rx_sync_sent) begin
        rx_fill_due <= 1'b1;
        rx_sync_sent <= 1'b1;
      end else if (rx_fill_due) begin
        // Filler byte marks the line's trailer when end handling is outside
        hs_recv_byte       <= {24'h0, `LPP_FILL_ZEROS};
        hs_recv_word_valid <= 4'h1;
        hs_recv_valid      <= 1'b1;
        rx_fill_due        <= 1'b0;
      end else begin
        hs_recv_active <= 1'b0;
        rx_inb         <= 1'b0;
        rx_sync_sent   <= 1'b0;
      end
    end
  end
endmodule // lpp_lane

// File: rtl/lpp_port.v
`timescale 1ns/100ps
`include "lpp_defines.vh"
module lpp_port #(
  parameter EXIT_CYCLES = `LPP_EXIT_CYCLES
) (
  // Clock and reset
  input  wire                        ref_clk,
  input  wire                        rst,
  // Configuration
  input  wire                        slave_side,
  input  wire                        eob_internal,
  input  wire                        test_mode_enter,
  input  wire                        test_mode_exit_cmd,
  input  wire                        both_lines_idle_high,
  output reg                         test_mode,
  // Per-lane send side
  input  wire [`LPP_LANES-1:0]       hs_send_request,
  input  wire [`LPP_LANES*32-1:0]    hs_send_byte,
  input  wire [`LPP_LANES*4-1:0]     hs_send_valid,
  input  wire [`LPP_LANES*2-1:0]     send_path_width_sel,
  output wire [`LPP_LANES-1:0]       hs_send_accept,
  // Per-lane line data
  output wire [`LPP_LANES*8-1:0]     line_tx_byte,
  output wire [`LPP_LANES-1:0]       line_tx_strobe,
  output wire [`LPP_LANES-1:0]       line_tx_burst,
  input  wire [`LPP_LANES-1:0]       line_rx_burst,
  input  wire [`LPP_LANES-1:0]       line_rx_strobe,
  input  wire [`LPP_LANES*8-1:0]     line_rx_byte,
  // Per-lane receive side
  input  wire [`LPP_LANES*2-1:0]     recv_path_width_sel,
  output wire [`LPP_LANES-1:0]       hs_recv_active,
  output wire [`LPP_LANES-1:0]       hs_recv_start_pulse,
  output wire [`LPP_LANES-1:0]       hs_recv_valid,
  output wire [`LPP_LANES*32-1:0]    hs_recv_byte,
  output wire [`LPP_LANES*4-1:0]     hs_recv_word_valid
);
  reg  [1:0]  idle_sync;
  reg  [31:0] idle_cnt;
  // Idle-high level comes from the line, so it is synchronised first
  always @(posedge ref_clk) begin
    if (rst)
      idle_sync <= 2'h0;
    else
      idle_sync <= {idle_sync[0], both_lines_idle_high};
  end
  // Test mode latches until long idle-high or explicit exit command
  always @(posedge ref_clk) begin
    if (rst) begin
      test_mode <= 1'b0;
      idle_cnt  <= 32'h0;
    end else begin
      idle_cnt <= (test_mode && idle_sync[1]) ? idle_cnt + 32'h1 : 32'h0;
      if (test_mode_exit_cmd)
        test_mode <= 1'b0;
      else if (test_mode && idle_sync[1] && idle_cnt >= EXIT_CYCLES - 1)
        test_mode <= 1'b0;
      else if (test_mode_enter)
        test_mode <= 1'b1;
    end
  end
  // One full copy of the lane logic per lane
  genvar g;
  generate
    for (g = 0; g < `LPP_LANES; g = g + 1) begin : g_lane
      lpp_lane u_lane (
        .ref_clk             (ref_clk),
        .rst                 (rst),
        .slave_side          (slave_side),
        .eob_internal        (eob_internal),
        .hs_send_request     (hs_send_request[g]),
        .hs_send_byte        (hs_send_byte[g*32 +: 32]),
        .hs_send_valid       (hs_send_valid[g*4 +: 4]),
        .send_path_width_sel (send_path_width_sel[g*2 +: 2]),
        .hs_send_accept      (hs_send_accept[g]),
        .line_tx_byte        (line_tx_byte[g*8 +: 8]),
        .line_tx_strobe      (line_tx_strobe[g]),
        .line_tx_burst       (line_tx_burst[g]),
        .line_rx_burst       (line_rx_burst[g]),
        .line_rx_strobe      (line_rx_strobe[g]),
        .line_rx_byte        (line_rx_byte[g*8 +: 8]),
        .recv_path_width_sel (recv_path_width_sel[g*2 +: 2]),
        .hs_recv_active      (hs_recv_active[g]),
        .hs_recv_start_pulse (hs_recv_start_pulse[g]),
        .hs_recv_valid       (hs_recv_valid[g]),
        .hs_recv_byte        (hs_recv_byte[g*32 +: 32]),
        .hs_recv_word_valid  (hs_recv_word_valid[g*4 +: 4])
      );
    end
  endgenerate
endmodule // lpp_port

// File: tb/lpp_port_props.sv
`timescale 1ns/100ps
module lpp_port_props #(
  parameter EXIT_CYCLES = 16
) (
  // Clock, reset and mode
  input wire       ref_clk,
  input wire       rst,
  input wire       slave_side,
  input wire       eob_internal,
  input wire       test_mode_exit_cmd,
  input wire       both_lines_idle_high,
  input wire       test_mode,
  // Send side
  input wire [1:0] hs_send_request,
  input wire [1:0] hs_send_accept,
  input wire [1:0] line_tx_strobe,
  input wire [1:0] line_tx_burst,
  // Receive side
  input wire [1:0] line_rx_burst,
  input wire [1:0] hs_recv_active,
  input wire [1:0] hs_recv_start_pulse,
  input wire [1:0] hs_recv_valid
);
  int idle_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Raw idle run; the design sees it later through its synchroniser
  always @(posedge ref_clk) idle_cnt <= (rst || !both_lines_idle_high) ? 0 : idle_cnt + 1;
  mode_holds_a: assert property (test_mode && !test_mode_exit_cmd && idle_cnt < EXIT_CYCLES
    |=> test_mode) else $error("test mode left early");
  exit_cmd_a: assert property (test_mode_exit_cmd |=> !test_mode)
    else $error("exit command ignored");
  send_start_a: assert property ($rose(hs_send_request[0]) && !line_tx_burst[0]
    |=> line_tx_burst[0]) else $error("burst did not start");
  strobe_in_burst_a: assert property (line_tx_strobe[0] |-> line_tx_burst[0])
    else $error("byte sent outside burst");
  send_stop_a: assert property ($fell(hs_send_request[0]) |-> ##[1:40] !line_tx_burst[0])
    else $error("burst did not stop");
  slave_accept_a: assert property (slave_side && hs_send_accept[0]
    |=> (!hs_send_accept[0] || !slave_side) [*3]) else $error("slave accept too often");
  start_on_burst_a: assert property ($rose(line_rx_burst[0])
    |=> hs_recv_active[0] && hs_recv_start_pulse[0]) else $error("no start pulse");
  start_one_cycle_a: assert property (hs_recv_start_pulse[0] |=> !hs_recv_start_pulse[0])
    else $error("start pulse too long");
  valid_in_active_a: assert property (hs_recv_valid[0]
    |-> hs_recv_active[0] && !hs_recv_start_pulse[0]) else $error("valid outside reception");
  active_stays_low_a: assert property (!hs_recv_active[0] && !line_rx_burst[0]
    |=> !hs_recv_active[0]) else $error("active rose without burst");
  eob_fall_a: assert property (eob_internal && $fell(line_rx_burst[0])
    |-> ##[1:6] !hs_recv_active[0]) else $error("active held after end");
  master_valid_a: assert property (!slave_side && line_rx_burst[0] && hs_recv_valid[0]
    |=> !hs_recv_valid[0] [*3]) else $error("master valid too often");
  cover property (hs_recv_start_pulse[0]);
  cover property (slave_side && hs_send_accept[0]);
  cover property ($fell(test_mode));
endmodule // lpp_port_props
bind lpp_port lpp_port_props #(.EXIT_CYCLES(EXIT_CYCLES)) chk (
  .ref_clk(ref_clk), .rst(rst), .slave_side(slave_side), .eob_internal(eob_internal),
  .test_mode_exit_cmd(test_mode_exit_cmd), .both_lines_idle_high(both_lines_idle_high),
  .test_mode(test_mode), .hs_send_request(hs_send_request), .hs_send_accept(hs_send_accept),
  .line_tx_strobe(line_tx_strobe), .line_tx_burst(line_tx_burst),
  .line_rx_burst(line_rx_burst), .hs_recv_active(hs_recv_active),
  .hs_recv_start_pulse(hs_recv_start_pulse), .hs_recv_valid(hs_recv_valid));

// File: tb/lpp_line_src.sv
`timescale 1ns/100ps
module lpp_line_src (
  // Bench control
  input  wire         ref_clk,
  input  wire         go,
  input  wire         slow,
  input  wire  [3:0]  n,
  input  wire  [63:0] data,
  // Line-side byte stream
  output logic        burst = 1'h0,
  output logic        strobe = 1'h0,
  output logic [7:0]  line_byte = 8'hA5
);
  int cnt, idx;
  // Slow lanes get a byte slot every fourth cycle; the idle byte line toggles
  // so that a stale value never passes for data
  always @(posedge ref_clk) begin
    strobe <= 1'h0;
    line_byte <= ~line_byte;
    if (go && !burst) begin
      burst <= 1'h1;
      idx <= 0;
      cnt <= 1;
    end else if (burst) begin
      cnt <= (cnt >= (slow ? 3 : 0)) ? 0 : cnt + 1;
      if (cnt == 0 && idx < n) begin
        strobe <= 1'h1;
        line_byte <= data[idx*8 +: 8];
        idx <= idx + 1;
      end else if (cnt == 0) burst <= 1'h0;
    end
  end
endmodule // lpp_line_src

// File: tb/test_lane_protocol_port_hs.sv
`timescale 1ns/100ps
module test_lane_protocol_port_hs;
  localparam int EXIT = 16;
  logic ref_clk = 0, rst = 1, slave_side = 0, eob_internal = 0, go = 0;
  logic tm_enter = 0, tm_exit = 0, idle_hi = 0, src_burst, src_strobe;
  logic [1:0] req = 0;
  logic [3:0] tx_w = 0, rx_w = 0, src_n = 0;
  logic [7:0] tx_flags = 0, src_byte;
  logic [63:0] tx_data = 0, src_data = 0;
  wire test_mode;
  wire [1:0] accept, tx_strobe, tx_burst, rx_act, rx_start, rx_valid;
  wire [15:0] tx_byte;
  wire [63:0] rx_byte;
  wire [7:0] rx_flags;
  int fail_count = 0, n_compared = 0, starts = 0, t, n;
  logic [7:0] txq[$], rxq[$], expq[$];
  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;
  lpp_port #(.EXIT_CYCLES(EXIT)) dut (
    .ref_clk(ref_clk), .rst(rst), .slave_side(slave_side), .eob_internal(eob_internal),
    .test_mode_enter(tm_enter), .test_mode_exit_cmd(tm_exit), .both_lines_idle_high(idle_hi),
    .test_mode(test_mode), .hs_send_request(req), .hs_send_byte(tx_data),
    .hs_send_valid(tx_flags), .send_path_width_sel(tx_w), .hs_send_accept(accept),
    .line_tx_byte(tx_byte), .line_tx_strobe(tx_strobe), .line_tx_burst(tx_burst),
    .line_rx_burst({2{src_burst}}), .line_rx_strobe({2{src_strobe}}),
    .line_rx_byte({2{src_byte}}), .recv_path_width_sel(rx_w), .hs_recv_active(rx_act),
    .hs_recv_start_pulse(rx_start), .hs_recv_valid(rx_valid), .hs_recv_byte(rx_byte),
    .hs_recv_word_valid(rx_flags));
  // A master lane hears a slave, which sends at a quarter of the rate
  lpp_line_src src (.ref_clk(ref_clk), .go(go), .slow(!slave_side), .n(src_n),
    .data(src_data), .burst(src_burst), .strobe(src_strobe), .line_byte(src_byte));
  // Take every lane 0 line byte and received group at once; reception cannot wait
  always @(posedge ref_clk) begin
    if (tx_strobe[0]) txq.push_back(tx_byte[7:0]);
    if (rx_start[0]) starts++;
    if (rx_valid[0]) for (int k = 0; k < 4; k++) if (rx_flags[k]) rxq.push_back(rx_byte[k*8+:8]);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] flags(input int w, input int left);
    for (int k = 0; k < 4; k++) flags[k] = (k <= w) && (k < left);
  endfunction
  function automatic logic [31:0] fill_ok(input logic [7:0] b);
    return {31'h0, b === 8'h00 || b === 8'hFF};
  endfunction
  // Groups of w+1 bytes, last one partial when n is not a multiple of w+1; width flipped mid-burst must not matter
  task automatic send_burst(input int n, input logic [1:0] w);
    int i, g;
    logic [31:0] d;
    logic [3:0] f;
    i = 0;
    tx_w <= {w, w};
    txq.delete();
    expq.delete();
    @(posedge ref_clk);
    while (i < n) begin
      d = $urandom;
      f = flags(w, n - i);
      for (int k = 0; k < 4; k++) if (f[k]) expq.push_back(d[k*8+:8]);
      req <= 2'h3;
      tx_data <= {d, d};
      tx_flags <= {f, f};
      g = 0;
      do begin @(negedge ref_clk); g++; end while (!accept[0] && g < 50);
      @(posedge ref_clk);
      if (i == 0) tx_w <= ~{w, w};
      i += w + 1;
    end
    req <= 2'h0;
    tx_data <= {2{$urandom}};
    g = 0;
    do begin @(negedge ref_clk); g++; end while ((g < 3 || tx_burst[0]) && g < 80);
    check(txq.size(), n);
    foreach (expq[j]) check(txq[j], expq[j]);
    check(tx_byte[15:8], tx_byte[7:0]);
  endtask
  task automatic recv_burst(input int n, input logic [1:0] w);
    int g;
    @(posedge ref_clk);
    rx_w <= {w, w};
    src_n <= 4'(n);
    src_data <= {$urandom, $urandom};
    rxq.delete();
    starts = 0;
    @(posedge ref_clk);
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    g = 0;
    do begin @(negedge ref_clk); g++; end while ((g < 4 || src_burst || rx_act[0]) && g < 90);
    check(starts, 32'h1);
    for (int j = 0; j < n; j++) check(rxq[j], src_data[j*8+:8]);
    if (!eob_internal) check(fill_ok(rxq[n]), 32'h1);
    check(rxq.size(), eob_internal ? n : n + 1);
    check(rx_byte[63:32], rx_byte[31:0]);
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(28188));
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    for (t = 0; t < 12; t++) begin
      @(posedge ref_clk);
      slave_side <= t[2];
      eob_internal <= t[0];
      n = (t < 2) ? 1 : 1 + $urandom % 8;
      send_burst(n, 2'($urandom));
      recv_burst(n, t[2] ? 2'($urandom) : 2'h0);
      $display("test %0d done", t);
    end
    @(posedge ref_clk);
    tm_enter <= 1'h1;
    @(posedge ref_clk);
    tm_enter <= 1'h0;
    idle_hi <= 1'h1;
    repeat (5) @(posedge ref_clk);
    check(test_mode, 32'h1);
    idle_hi <= 1'h0;
    tm_exit <= 1'h1;
    @(posedge ref_clk);
    tm_exit <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check(test_mode, 32'h0);
    tm_enter <= 1'h1;
    @(posedge ref_clk);
    tm_enter <= 1'h0;
    idle_hi <= 1'h1;
    repeat (EXIT + 8) @(posedge ref_clk);
    check(test_mode, 32'h0);
    $display("test mode done");
    final_report;
  end
  // Cut a hang short well past the longest expected run
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    final_report;
  end
endmodule // test_lane_protocol_port_hs
